// >>> core/pport_pkg.sv
package pport_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [4:0] DATA_OFS = 5'h00;
	localparam logic [4:0] STATUS_OFS = 5'h04;
	localparam logic [4:0] CONTROL_OFS = 5'h08;
	localparam logic [4:0] MODE_OFS = 5'h0C;
	localparam logic [4:0] RXBYTE_OFS = 5'h10;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTL_STROBE_BIT = 0;
	localparam int CTL_HANDSHAKE_BIT = 1;
	localparam int CTL_INIT_BIT = 2;
	localparam int CTL_SELECT_BIT = 3;
	localparam int CTL_IEN_BIT = 4;
	localparam int CTL_DIR_BIT = 5;
	localparam logic [5:0] CTL_RESET = 6'h00;

	// ****************************************
	// Status register fields
	// ****************************************
	localparam int ST_IRQ_BIT = 2;
	localparam int ST_FAULT_BIT = 3;
	localparam int ST_SELECT_BIT = 4;
	localparam int ST_PAPER_ERROR_BIT = 5;
	localparam int ST_ACK_BIT = 6;
	localparam int ST_BUSY_BIT = 7;

	// ****************************************
	// Mode and receive fields
	// ****************************************
	localparam int MODE_BYTE_BIT = 0;
	localparam logic MODE_RESET = 1'b0;
	localparam int RX_VALID_BIT = 8;
	localparam int RX_HALF_BIT = 9;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// ****************************************
	// Widths and synchroniser
	// ****************************************
	localparam int DATA_W = 8;
	localparam int SYNC_W = 13;

	// ****************************************
	// Pin carriers
	// ****************************************
	typedef struct packed {
		logic busy;
		logic ack_n;
		logic select;
		logic paper_error_line;
		logic fault_n;
	} pins_in_t;

	typedef struct packed {
		logic strobe_n;
		logic handshake_n;
		logic init_n;
		logic select_n;
	} pins_out_t;

	typedef enum logic {
		NIBBLE_MODE,
		BYTE_MODE
	} port_mode_t;

endpackage

// >>> core/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	// ****************************************
	// Two-stage synchroniser
	// ****************************************
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule

// >>> core/pport_reverse.sv
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Function
// [RULE1] Handshake and pulse outputs are active low on the pins.
// [RULE2] Peripheral sends data bits 3 then 7 on busy in nibble mode.
// [RULE3] Peripheral sends data bits 1 then 5 on online flag in nibble mode.
// [RULE4] Peripheral sends data bits 2 then 6 on paper error line after acknowledge.
// [RULE5] Peripheral sends data bits 0 then 4 on error flag after data available.
// [RULE6] Peripheral pulls error flag low to announce available data.
// [RULE7] Paper error line starts high, falls to acknowledge host handshake.
// [RULE8] Peripheral clock announces data, then qualifies each data unit.
// [RULE9] Peripheral clock assertion raises interrupt when interrupt enable is set.
// [RULE10] Host negates handshake on peripheral clock, then drives it low.
// [RULE11] Host drives handshake high after taking each data unit.
// [RULE12] Host keeps pulse output negated in nibble mode via control register.
// [RULE13] Host keeps peripheral reset negated in byte mode.
// [RULE14] Host pulses pulse output low after receiving a byte.
// [RULE15] Peripheral must not treat host pulse as forward latch strobe.
// [RULE16] Busy line reports forward channel busy in byte mode.
// [RULE17] Online flag asserted while peripheral is on line in byte mode.
// [RULE18] Byte mode uses the data bus in both directions.
// [RULE19] Nibble mode drives the data bus as output only.
// [RULE20] Each peripheral input level is readable in the status register.
// [RULE21] Device select output follows control register in both modes.
// [RULE22] Interrupt enable is control register bit 4.
// [RULE23] Nibble bytes assemble first nibble low, second nibble high.

module pport_reverse (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire pport_pkg::pins_in_t pins_i,
	output pport_pkg::pins_out_t pins_o,
	input wire logic [pport_pkg::DATA_W-1:0] port_data_bus_i,
	output logic [pport_pkg::DATA_W-1:0] port_data_bus_o,
	output logic port_data_bus_oe_o,
	output logic irq_o
);
	import pport_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic [SYNC_W-1:0] sync_w;
	pins_in_t pin_s;
	logic [DATA_W-1:0] bus_s;
	logic ack_n_d_r;
	logic clk_evt;
	logic [5:0] ctl_r;
	port_mode_t mode_r;
	logic [DATA_W-1:0] data_r;
	logic irq_r;
	logic [DATA_W-1:0] rx_r;
	logic rx_valid_r;
	logic rx_half_r;
	logic req;
	logic wr_en;
	logic rd_status;
	logic rd_rx;
	logic [31:0] rd_data;
	logic [3:0] nib;
	logic wr_data;
	logic wr_ctl;
	logic wr_mode;
	logic wr_rx;
	logic ien;

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic hit(input logic [4:0] adr, input logic [4:0] ofs);
		hit = (adr == ofs);
	endfunction

	function automatic logic is_byte(input port_mode_t m);
		is_byte = (m == BYTE_MODE);
	endfunction

	// ****************************************
	// Input synchronisation
	// ****************************************
	pin_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({pins_i, port_data_bus_i}),
		.sync_o(sync_w)
	);

	assign pin_s = sync_w[SYNC_W-1:DATA_W];
	assign bus_s = sync_w[DATA_W-1:0];

	// ****************************************
	// Peripheral clock edge
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Low while synchroniser fills, so no false edge
			ack_n_d_r <= 1'b0;
		end else begin
			ack_n_d_r <= pin_s.ack_n;
		end
	end

	// [RULE8] Clock assertion detect
	assign clk_evt = ack_n_d_r & ~pin_s.ack_n;

	// ****************************************
	// Bus decode
	// ****************************************
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr_en = req & we_i & sel_i[0];
	assign rd_status = req & ~we_i & hit(adr_i, STATUS_OFS);
	assign rd_rx = req & ~we_i & hit(adr_i, RXBYTE_OFS);
	assign wr_data = wr_en & hit(adr_i, DATA_OFS);
	assign wr_ctl = wr_en & hit(adr_i, CONTROL_OFS);
	assign wr_mode = wr_en & hit(adr_i, MODE_OFS);
	assign wr_rx = wr_en & hit(adr_i, RXBYTE_OFS);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// ****************************************
	// Control register
	// ****************************************
	// [RULE22] Interrupt enable bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_r <= CTL_RESET;
		end else if (wr_ctl) begin
			ctl_r <= dat_i[5:0];
		end
	end

	assign ien = ctl_r[CTL_IEN_BIT];

	// ****************************************
	// Mode register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= port_mode_t'(MODE_RESET);
		end else if (wr_mode) begin
			mode_r <= port_mode_t'(dat_i[MODE_BYTE_BIT]);
		end
	end

	// ****************************************
	// Forward data register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_r <= DATA_RESET;
		end else if (wr_data) begin
			data_r <= dat_i[DATA_W-1:0];
		end
	end

	// ****************************************
	// Pin outputs
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins_o <= '{strobe_n: 1'b1, handshake_n: 1'b1, init_n: 1'b1, select_n: 1'b1};
		end else begin
			// [RULE1] Asserted means low
			pins_o.strobe_n <= ~ctl_r[CTL_STROBE_BIT];
			pins_o.handshake_n <= ~ctl_r[CTL_HANDSHAKE_BIT];
			pins_o.init_n <= ~ctl_r[CTL_INIT_BIT];
			// [RULE21] Select from control
			pins_o.select_n <= ~ctl_r[CTL_SELECT_BIT];
		end
	end

	// ****************************************
	// Data bus direction
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_data_bus_o <= DATA_RESET;
			port_data_bus_oe_o <= 1'b1;
		end else begin
			port_data_bus_o <= data_r;
			// [RULE18] Byte mode turnaround
			// [RULE19] Nibble mode output only
			port_data_bus_oe_o <= !(is_byte(mode_r) && ctl_r[CTL_DIR_BIT]);
		end
	end

	// ****************************************
	// Interrupt flag
	// ****************************************
	// [RULE9] Interrupt on clock assertion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_r <= 1'b0;
		end else if (clk_evt && ien) begin
			irq_r <= 1'b1;
		end else if (rd_status || !ien) begin
			irq_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_r;
		end
	end

	// ****************************************
	// Reverse data capture
	// ****************************************
	// [RULE2] [RULE3] [RULE4] [RULE5] Nibble bit order
	assign nib = {pin_s.busy, pin_s.paper_error_line, pin_s.select, pin_s.fault_n};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_r <= DATA_RESET;
			rx_half_r <= 1'b0;
		end else if (clk_evt && is_byte(mode_r)) begin
			rx_r <= bus_s;
			rx_half_r <= 1'b0;
		end else if (clk_evt && !rx_half_r) begin
			// [RULE23] First nibble low
			rx_r[3:0] <= nib;
			rx_half_r <= 1'b1;
		end else if (clk_evt) begin
			rx_r[7:4] <= nib;
			rx_half_r <= 1'b0;
		end else if (wr_rx) begin
			rx_half_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_valid_r <= 1'b0;
		end else if (clk_evt && (is_byte(mode_r) || rx_half_r)) begin
			rx_valid_r <= 1'b1;
		end else if (rd_rx) begin
			rx_valid_r <= 1'b0;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rd_data = 32'h0000_0000;
		case (adr_i)
			DATA_OFS: begin
				rd_data[DATA_W-1:0] = port_data_bus_oe_o ? data_r : bus_s;
			end
			STATUS_OFS: begin
				// [RULE20] Pin levels visible
				rd_data[ST_IRQ_BIT] = irq_r;
				rd_data[ST_FAULT_BIT] = pin_s.fault_n;
				rd_data[ST_SELECT_BIT] = pin_s.select;
				rd_data[ST_PAPER_ERROR_BIT] = pin_s.paper_error_line;
				rd_data[ST_ACK_BIT] = pin_s.ack_n;
				rd_data[ST_BUSY_BIT] = pin_s.busy;
			end
			CONTROL_OFS: begin
				rd_data[5:0] = ctl_r;
			end
			MODE_OFS: begin
				rd_data[MODE_BYTE_BIT] = is_byte(mode_r);
			end
			RXBYTE_OFS: begin
				rd_data[DATA_W-1:0] = rx_r;
				rd_data[RX_VALID_BIT] = rx_valid_r;
				rd_data[RX_HALF_BIT] = rx_half_r;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (req && !we_i) begin
			dat_o <= rd_data;
		end
	end

endmodule

// >>> verification/pport_props.sv
`timescale 1ns/1ps
module pport_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic [31:0] dat_o,
	input wire pport_pkg::pins_in_t pins_i,
	input wire pport_pkg::pins_out_t pins_o,
	input wire logic [pport_pkg::DATA_W-1:0] port_data_bus_o,
	input wire logic port_data_bus_oe_o,
	input wire logic irq_o
);
	import pport_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (
		ack_o |=> !ack_o) else $error("ack held");
	a_ack_answer: assert property (
		cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	a_irq_cause: assert property (
		$rose(irq_o) |-> !$past(pins_i.ack_n, 3) || !$past(pins_i.ack_n, 4)
		|| !$past(pins_i.ack_n, 5)) else $error("irq without clock");
	a_irq_hold: assert property (
		irq_o && !cyc_i && !$past(cyc_i) |=> irq_o) else $error("irq lost");
	a_pins_write: assert property (
		!$stable(pins_o) |-> $past(ack_o && we_i)) else $error("pins moved");
	a_bus_write: assert property (
		$changed(port_data_bus_o) |-> $past(ack_o) && $past(we_i)) else $error("bus moved");
	a_oe_turn: assert property (
		$fell(port_data_bus_oe_o) |-> $past(ack_o && we_i)) else $error("oe fell");
	a_dat_read: assert property (
		$changed(dat_o) |-> ack_o && !we_i) else $error("dat moved");
	c_irq: cover property ($rose(irq_o));
	c_turn: cover property ($fell(port_data_bus_oe_o));
	c_read: cover property (ack_o && !we_i);
endmodule

bind pport_reverse pport_props u_pport_props (.clk_i, .rst_i, .we_i, .cyc_i, .stb_i,
	.ack_o, .dat_o, .pins_i, .pins_o, .port_data_bus_o, .port_data_bus_oe_o, .irq_o);

// >>> verification/pport_peer.sv
`timescale 1ns/1ps
module pport_peer (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic byte_i,
	input wire logic [7:0] d_i,
	input wire logic hs_n_i,
	output pport_pkg::pins_in_t pins_o,
	output logic [7:0] bus_o,
	output logic busy_o
);
	import pport_pkg::*;
	logic drv;
	// Released bus shows inverse
	assign bus_o = drv ? d_i : ~d_i;
	task automatic pulse();
		@(posedge clk_i);
		pins_o.ack_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		pins_o.ack_n <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask
	initial begin
		pins_o = 5'b01111;
		drv = 1'b0;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i) begin
				busy_o <= 1'b1;
				pins_o.fault_n <= 1'b0;
				pulse();
				while (hs_n_i) @(posedge clk_i);
				pins_o.paper_error_line <= 1'b0;
				repeat (2) @(posedge clk_i);
				if (byte_i) begin
					drv <= 1'b1;
					pulse();
				end else begin
					for (int k = 0; k < 2; k++) begin
						{pins_o.busy, pins_o.paper_error_line} <= d_i[4*k+2+:2];
						{pins_o.select, pins_o.fault_n} <= d_i[4*k+:2];
						pulse();
					end
				end
				drv <= 1'b0;
				pins_o <= 5'b01111;
				busy_o <= 1'b0;
			end
		end
	end
endmodule

// >>> verification/pport_reverse_tb_top.sv
`timescale 1ns/1ps
module pport_reverse_tb_top;
	import pport_pkg::*;
	logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, irq_o, port_data_bus_oe_o, go, bm, pbusy;
	logic [4:0] adr_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0] sel_i;
	logic [7:0] d, peer_bus, port_data_bus_i, port_data_bus_o;
	pins_in_t pins_i;
	pins_out_t pins_o;
	int miscompares, n_checks;
	assign port_data_bus_i = port_data_bus_oe_o ? port_data_bus_o : peer_bus;
	pport_reverse u_pport_reverse (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i,
		.cyc_i, .stb_i, .ack_o, .pins_i, .pins_o, .port_data_bus_i, .port_data_bus_o,
		.port_data_bus_oe_o, .irq_o);
	pport_peer u_pport_peer (.clk_i, .go_i(go), .byte_i(bm), .d_i(d),
		.hs_n_i(pins_o.handshake_n), .pins_o(pins_i), .bus_o(peer_bus), .busy_o(pbusy));
	task automatic test_done();
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] v,
		output logic [31:0] r);
		int k;
		@(posedge clk_i);
		adr_i <= a;
		we_i <= w;
		dat_i <= {24'h000000, v};
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 20);
		if (ack_o !== 1'b1) begin
			miscompares++;
			test_done();
		end
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(a, 1'b0, 8'h00, r);
		chk(r, e);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		logic [31:0] r;
		wb(a, 1'b1, v, r);
	endtask
	task automatic xfer(input logic [7:0] c, input logic [7:0] v, input logic m);
		int k;
		wr(CONTROL_OFS, c);
		d <= v;
		bm <= m;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (12) @(posedge clk_i);
		wr(RXBYTE_OFS, 8'h00);
		wr(CONTROL_OFS, c | 8'h02);
		k = 0;
		while (pbusy && k < 200) begin
			@(posedge clk_i);
			k++;
		end
		if (pbusy) begin
			miscompares++;
			test_done();
		end
		if (m) begin
			wr(CONTROL_OFS, c | 8'h03);
			@(posedge clk_i);
			chk(32'(pins_o), 32'h00000002);
		end
		wr(CONTROL_OFS, c);
		repeat (3) @(posedge clk_i);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		{adr_i, dat_i, we_i, cyc_i, stb_i, go, bm, d} = '0;
		sel_i = 4'hF;
		miscompares = 0;
		n_checks = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(32'(pins_o), 32'h0000000F);
		rd(CONTROL_OFS, 32'h00000000);
		rd(STATUS_OFS, 32'h00000078);
		rd(5'h14, 32'h00000000);
		wr(DATA_OFS, 8'hA5);
		wr(CONTROL_OFS, 8'h0B);
		repeat (2) @(posedge clk_i);
		chk(32'(pins_o), 32'h00000002);
		chk(32'(port_data_bus_o), 32'h000000A5);
		xfer(8'h08, 8'h5A, 1'b0);
		chk(32'(irq_o), 32'h00000000);
		rd(RXBYTE_OFS, 32'h0000015A);
		xfer(8'h18, 8'h6C, 1'b0);
		chk(32'(irq_o), 32'h00000001);
		rd(STATUS_OFS, 32'h0000007C);
		rd(RXBYTE_OFS, 32'h0000016C);
		wr(MODE_OFS, 8'h01);
		wr(CONTROL_OFS, 8'h38);
		repeat (2) @(posedge clk_i);
		chk(32'(port_data_bus_oe_o), 32'h00000000);
		xfer(8'h38, 8'h3C, 1'b1);
		rd(RXBYTE_OFS, 32'h0000013C);
		rd(DATA_OFS, 32'h000000C3);
		wr(MODE_OFS, 8'h00);
		repeat (2) @(posedge clk_i);
		chk(32'(port_data_bus_oe_o), 32'h00000001);
		test_done();
	end
endmodule
